// ### include/tio_pkg.sv
// Constants and types shared by the timed I/O port block
//
// Summary of operation
// - Ports of 1, 4, 8, 16, 32 bits
// - All pins of a port share direction
// - Drive pins or sample, optional condition wait
// - Core access completes in one cycle
// - Open collector: low for zero, float one
// - Transfer register plus shift stage buffering
// - Sixteen-bit port counter times transfers
// - Counter readable; I/O deferrable to time
// - Counter captured as timestamp per transfer
// - Enabled link disables underlying port pins
// - Narrower enabled port overrules wider port
// - Unshared wider-port pins stay usable
// - Ports always transfer at own width
// - Six clock blocks; block zero reference
// - Other blocks run at configurable rates
// - Clock block may use one-bit port
// - Port-sourced clock optionally divided
// - Strobe inputs honoured, strobe outputs generated
// - After reset ports use block zero
// - Pin events delivered straight to core
// - Pull-downs enabled while in reset
`default_nettype none

package tio_pkg;

  // -------------------------------------------------------------------
  // Sizes and timing
  // -------------------------------------------------------------------
  localparam int NUM_PORTS = 5;
  localparam int NUM_PINS = 32;
  localparam int NUM_CLKBLK = 6;
  localparam int CNT_W = 16;
  localparam int unsigned PORT_WIDTH [NUM_PORTS] = '{1, 4, 8, 16, 32};
  localparam int SYS_FREQ_MHZ = 200;
  localparam int REF_FREQ_MHZ = 100;
  localparam int REF_DIV = SYS_FREQ_MHZ / REF_FREQ_MHZ;
  localparam int LINK_PIN_LO = 28;

  // -------------------------------------------------------------------
  // Register map, word indices
  // -------------------------------------------------------------------
  localparam logic [7:0] PORT_AREA_END = 8'h28;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h1;
  localparam logic [2:0] REG_TIME = 3'h2;
  localparam logic [2:0] REG_COUNT = 3'h3;
  localparam logic [2:0] REG_TSTAMP = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_COND = 3'h6;
  localparam logic [7:0] CLKBLK_BASE = 8'h30;
  localparam logic [7:0] LINK_CTRL = 8'h38;

  // -------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_OC = 2;
  localparam int CTRL_STB = 3;
  localparam int CTRL_COND_LSB = 4;
  localparam int CTRL_CLK_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CB_DIV_LSB = 0;
  localparam int CB_SRC = 8;
  localparam logic [8:0] CB_RST = 9'h000;

  // Input wait condition
  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ = 2'b01,
    COND_NE = 2'b10
  } cond_t;

endpackage

`default_nettype wire

// ### include/port_if.sv
// Control and data bundle between the top level and one port unit
`default_nettype none

interface port_if #(parameter int W = 1);
  logic tick;
  logic en;
  logic dir_out;
  logic strobe_en;
  logic [1:0] cond_mode;
  logic [31:0] wdata;
  logic data_wr;
  logic time_wr;
  logic cond_wr;
  logic data_rd;
  logic [W-1:0] pin_in;
  logic strobe_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] in_data;
  logic [15:0] count;
  logic [15:0] tstamp;
  logic in_valid;
  logic out_pend;
  logic timed;
  logic strobe_out;
  logic event_pulse;

  modport ctl (
    output tick, en, dir_out, strobe_en, cond_mode, wdata, data_wr,
    output time_wr, cond_wr, data_rd, pin_in, strobe_in,
    input pin_out, in_data, count, tstamp, in_valid, out_pend, timed,
    input strobe_out, event_pulse
  );
  modport unit (
    input tick, en, dir_out, strobe_en, cond_mode, wdata, data_wr,
    input time_wr, cond_wr, data_rd, pin_in, strobe_in,
    output pin_out, in_data, count, tstamp, in_valid, out_pend, timed,
    output strobe_out, event_pulse
  );
endinterface

`default_nettype wire

// ### rtl/clock_block.sv
// One programmable clock block producing a port tick pulse
`default_nettype none

module clock_block
  import tio_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Sources and setup
  input wire logic ref_tick_i,
  input wire logic ext_clk_i,
  input wire logic src_ext_i,
  input wire logic [7:0] div_i,
  // Tick out
  output logic tick_o
);

  logic ext_d_r;
  logic [7:0] div_cnt_r;
  logic src_evt;

  // rising edge of port pin as source
  assign src_evt = src_ext_i ? (ext_clk_i & ~ext_d_r) : ref_tick_i;
  assign tick_o = src_evt & (div_cnt_r >= div_i);

  // Edge memory of the external clock level
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ext_d_r <= 1'b0;
    else
      ext_d_r <= ext_clk_i;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_cnt_r <= 8'h00;
    else if (tick_o)
      div_cnt_r <= 8'h00;
    else if (src_evt)
      div_cnt_r <= div_cnt_r + 8'h01;
  end

endmodule // clock_block

`default_nettype wire

// ### rtl/port_unit.sv
// One port: transfer buffer, counter, timestamp, condition and strobe
`default_nettype none

module port_unit
  import tio_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Link to top
  port_if.unit pif
);

  logic [W-1:0] tx_r, out_r, rx_r, cond_r;
  logic [CNT_W-1:0] cnt_r, time_r, ts_r;
  logic pend_r, timed_r, valid_r, stb_r, evt_r;
  logic at_time, in_match, move_out, take_in;

  // hold until counter equals programmed time
  assign at_time = ~timed_r | (cnt_r == time_r);
  assign in_match = (pif.cond_mode == COND_EQ) ? (pif.pin_in == cond_r) :
                    (pif.cond_mode == COND_NE) ? (pif.pin_in != cond_r) :
                    1'b1;
  assign move_out = pif.tick & pif.en & pif.dir_out & pend_r & at_time;
  assign take_in = pif.tick & pif.en & ~pif.dir_out & at_time & in_match &
                   (~pif.strobe_en | pif.strobe_in);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cnt_r <= '0;
    else if (pif.tick)
      cnt_r <= cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_r <= '0;
      out_r <= '0;
      pend_r <= 1'b0;
    end
    else
    begin
      if (pif.data_wr)
        tx_r <= pif.wdata[W-1:0];
      if (move_out)
        out_r <= tx_r;
      pend_r <= pif.data_wr | (pend_r & ~move_out);
    end
  end

  // timed arm, cleared by its transfer
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      time_r <= '0;
      timed_r <= 1'b0;
      cond_r <= '0;
    end
    else
    begin
      if (pif.time_wr)
        time_r <= pif.wdata[CNT_W-1:0];
      if (pif.cond_wr)
        cond_r <= pif.wdata[W-1:0];
      timed_r <= pif.time_wr | (timed_r & ~(move_out | take_in));
    end
  end

  // timestamp and captured input; capture beats read clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ts_r <= '0;
      rx_r <= '0;
      valid_r <= 1'b0;
      evt_r <= 1'b0;
    end
    else
    begin
      if (move_out | take_in)
        ts_r <= cnt_r;
      if (take_in)
        rx_r <= pif.pin_in;
      valid_r <= take_in | (valid_r & ~pif.data_rd);
      evt_r <= take_in | move_out;
    end
  end

  // strobe out for one port period per word
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      stb_r <= 1'b0;
    else if (move_out)
      stb_r <= pif.strobe_en;
    else if (pif.tick)
      stb_r <= 1'b0;
  end

  assign pif.pin_out = out_r;
  assign pif.in_data = rx_r;
  assign pif.count = cnt_r;
  assign pif.tstamp = ts_r;
  assign pif.in_valid = valid_r;
  assign pif.out_pend = pend_r;
  assign pif.timed = timed_r;
  assign pif.strobe_out = stb_r;
  assign pif.event_pulse = evt_r;

endmodule // port_unit

`default_nettype wire

// ### rtl/timed_io_top.sv
// Timed I/O ports with clock blocks, pin sharing and register port
//
// Local design decisions: strobed register access and the register addresses.
`default_nettype none

module timed_io_top
  import tio_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Physical pins
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_n_o,
  output logic pull_dn_o,
  // Strobes
  input wire logic [NUM_PORTS-1:0] strobe_input_i,
  output logic [NUM_PORTS-1:0] strobe_output_o,
  // Core side events and link state
  output logic [NUM_PORTS-1:0] event_o,
  output logic link_en_o
);

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  logic [31:0] ctrl_r [NUM_PORTS];
  logic [8:0] cb_cfg_r [NUM_CLKBLK];
  logic link_en_r;
  logic pull_dn_r;
  logic [31:0] rdata_r;
  logic [NUM_PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
  logic [NUM_PORTS-1:0] stb_s1_r, stb_s2_r, stb_s3_r, stb_q_r;
  logic [NUM_PINS-1:0] pin_out_r, pin_oe_n_r;
  logic [NUM_PINS-1:0] drv_en, drv_val;
  logic [$clog2(REF_DIV)-1:0] ref_cnt_r;
  logic ref_tick;
  logic [NUM_CLKBLK-1:0] cb_tick;
  logic [31:0] p_out [NUM_PORTS];
  logic [31:0] p_in [NUM_PORTS];
  logic [15:0] p_cnt [NUM_PORTS];
  logic [15:0] p_ts [NUM_PORTS];
  logic [31:0] p_stat [NUM_PORTS];
  logic [NUM_PORTS-1:0] p_stb_out, p_evt;
  logic port_hit;
  logic [2:0] port_sel;
  logic [2:0] reg_sel;
  logic cb_hit;
  logic [2:0] cb_sel;
  logic [31:0] rd_mux;

  // -------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------
  // Ports sit eight words apart from index zero
  assign port_hit = addr_i < PORT_AREA_END;
  assign port_sel = addr_i[5:3];
  assign reg_sel = addr_i[2:0];
  assign cb_hit = (addr_i >= CLKBLK_BASE) &&
                  (addr_i < CLKBLK_BASE + 8'(NUM_CLKBLK));
  assign cb_sel = 3'(addr_i - CLKBLK_BASE);

  // -------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_q_r <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) |
                 (pin_q_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  // Strobe inputs take the same filtered path
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stb_s1_r <= '0;
      stb_s2_r <= '0;
      stb_s3_r <= '0;
      stb_q_r <= '0;
    end
    else
    begin
      stb_s1_r <= strobe_input_i;
      stb_s2_r <= stb_s1_r;
      stb_s3_r <= stb_s2_r;
      stb_q_r <= (stb_s2_r & ~(stb_s2_r ^ stb_s3_r)) |
                 (stb_q_r & (stb_s2_r ^ stb_s3_r));
    end
  end

  // -------------------------------------------------------------------
  // Reference clock and clock blocks
  // -------------------------------------------------------------------
  // reference tick at reference rate
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ref_cnt_r <= '0;
    else if (ref_tick)
      ref_cnt_r <= '0;
    else
      ref_cnt_r <= ref_cnt_r + 1'b1;
  end

  assign ref_tick = (ref_cnt_r == ($clog2(REF_DIV))'(REF_DIV - 1));

  // six blocks, block zero fixed to reference
  generate
    for (genvar c = 0; c < NUM_CLKBLK; c++)
    begin : g_cb
      // Block zero ignores its setup so it stays the reference
      clock_block u_cb (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .ref_tick_i (ref_tick),
        .ext_clk_i (pin_q_r[0]),
        .src_ext_i ((c == 0) ? 1'b0 : cb_cfg_r[c][CB_SRC]),
        .div_i ((c == 0) ? 8'h00 : cb_cfg_r[c][CB_DIV_LSB +: 8]),
        .tick_o (cb_tick[c])
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  // reset selects clock block zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
        ctrl_r[p] <= CTRL_RST;
    end
    else if (wr_i && port_hit && reg_sel == REG_CTRL)
      ctrl_r[port_sel] <= wdata_i;
  end

  // blocks one to five take setup
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int c = 0; c < NUM_CLKBLK; c++)
        cb_cfg_r[c] <= CB_RST;
    end
    else if (wr_i && cb_hit && cb_sel != 3'd0)
      cb_cfg_r[cb_sel] <= wdata_i[8:0];
  end

  // Link enable register
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      link_en_r <= 1'b0;
    else if (wr_i && addr_i == LINK_CTRL)
      link_en_r <= wdata_i[0];
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pull_dn_r <= 1'b1;
    else
      pull_dn_r <= 1'b0;
  end

  // -------------------------------------------------------------------
  // Ports
  // -------------------------------------------------------------------
  // one unit per width
  generate
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
      localparam int W = int'(PORT_WIDTH[g]);
      logic [2:0] clk_sel;
      logic hit;

      port_if #(.W(W)) pif ();

      assign clk_sel = ctrl_r[g][CTRL_CLK_LSB +: 3];
      assign hit = wr_i && port_hit && port_sel == 3'(g);

      // tick from the selected clock block
      assign pif.tick = (clk_sel < 3'(NUM_CLKBLK)) ? cb_tick[clk_sel] :
                        1'b0;
      assign pif.en = ctrl_r[g][CTRL_EN];
      assign pif.dir_out = ctrl_r[g][CTRL_DIR];
      assign pif.strobe_en = ctrl_r[g][CTRL_STB];
      assign pif.cond_mode = ctrl_r[g][CTRL_COND_LSB +: 2];
      assign pif.wdata = wdata_i;
      // each access is a single strobe cycle
      assign pif.data_wr = hit && reg_sel == REG_DATA;
      assign pif.time_wr = hit && reg_sel == REG_TIME;
      assign pif.cond_wr = hit && reg_sel == REG_COND;
      assign pif.data_rd = rd_i && port_hit && port_sel == 3'(g) &&
                           reg_sel == REG_DATA;
      // port reads all its pins whoever drives them
      assign pif.pin_in = pin_q_r[W-1:0];
      assign pif.strobe_in = stb_q_r[g];

      port_unit #(.W(W)) u_port (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .pif (pif.unit)
      );

      // Widen results for the shared muxes
      assign p_out[g] = 32'(pif.pin_out);
      assign p_in[g] = 32'(pif.in_data);
      assign p_cnt[g] = pif.count;
      assign p_ts[g] = pif.tstamp;
      assign p_stat[g] = {29'h0000_0000, pif.timed, pif.out_pend,
                          pif.in_valid};
      assign p_stb_out[g] = pif.strobe_out;
      assign p_evt[g] = pif.event_pulse;
    end
  endgenerate

  // -------------------------------------------------------------------
  // Pin ownership
  // -------------------------------------------------------------------
  // Widest first so a narrower enabled port lands last and wins
  generate
    for (genvar k = 0; k < NUM_PINS; k++)
    begin : g_pin
      always_comb
      begin
        drv_en[k] = 1'b0;
        drv_val[k] = 1'b0;
        for (int p = NUM_PORTS - 1; p >= 0; p--)
        begin
          // narrower port overrules, rest stays with wider
          if (ctrl_r[p][CTRL_EN] && k < int'(PORT_WIDTH[p]))
          begin
            drv_en[k] = ctrl_r[p][CTRL_DIR];
            // open collector only ever drives low
            if (ctrl_r[p][CTRL_OC])
            begin
              drv_val[k] = 1'b0;
              drv_en[k] = ctrl_r[p][CTRL_DIR] & ~p_out[p][k];
            end
            else
              drv_val[k] = p_out[p][k];
          end
        end
        // link takes its pins from all ports
        if (link_en_r && k >= LINK_PIN_LO)
        begin
          drv_en[k] = 1'b0;
          drv_val[k] = 1'b0;
        end
      end
    end
  endgenerate

  // Pin drivers registered so the pads see no decode glitches
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end
    else
    begin
      pin_out_r <= drv_val;
      pin_oe_n_r <= ~drv_en;
    end
  end

  // -------------------------------------------------------------------
  // Read back
  // -------------------------------------------------------------------
  // counter, timestamp and data readable any time
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (port_hit)
    begin
      case (reg_sel)
        REG_CTRL: rd_mux = ctrl_r[port_sel];
        REG_DATA: rd_mux = p_in[port_sel];
        REG_COUNT: rd_mux = {16'h0000, p_cnt[port_sel]};
        REG_TSTAMP: rd_mux = {16'h0000, p_ts[port_sel]};
        REG_STATUS: rd_mux = p_stat[port_sel];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
    else if (cb_hit)
      rd_mux = {23'h00_0000, cb_cfg_r[cb_sel]};
    else if (addr_i == LINK_CTRL)
      rd_mux = {31'h0000_0000, link_en_r};
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_r <= 32'h0000_0000;
    else if (rd_i)
      rdata_r <= rd_mux;
    else
      rdata_r <= 32'h0000_0000;
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign rdata_o = rdata_r;
  assign pin_o = pin_out_r;
  assign pin_oe_n_o = pin_oe_n_r;
  assign pull_dn_o = pull_dn_r;
  assign strobe_output_o = p_stb_out;
  // events go straight out, no interrupt logic
  assign event_o = p_evt;
  assign link_en_o = link_en_r;

endmodule // timed_io_top

`default_nettype wire

// ### verification/timed_io_properties.sv
// Port-level assertions for the timed I/O top
`default_nettype none
module timed_io_properties
  import tio_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Pins, strobes, events
  input wire logic [NUM_PINS-1:0] pin_i,
  input wire logic [NUM_PINS-1:0] pin_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n_o,
  input wire logic pull_dn_o,
  input wire logic [NUM_PORTS-1:0] strobe_input_i,
  input wire logic [NUM_PORTS-1:0] strobe_output_o,
  input wire logic [NUM_PORTS-1:0] event_o,
  input wire logic link_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---
  // Checks
  // ---
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_pull_off_run: assert property (
    $past(reset_n_i) |-> !pull_dn_o)
    else $error("pull-down left on after reset");
  a_drive_no_pull: assert property (
    pin_oe_n_o != '1 |-> !pull_dn_o)
    else $error("pin driven against pull-down");
  a_rdata_idle_zero: assert property (
    !$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  a_unmapped_read: assert property (
    rd_i && addr_i > LINK_CTRL |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_event_single: assert property (
    (event_o & $past(event_o)) == '0)
    else $error("event longer than one cycle");
  a_link_pins_off: assert property (
    link_en_o [*2] |-> pin_oe_n_o[31:28] == 4'hF)
    else $error("link pins still driven");
  a_strobe_with_event: assert property (
    (strobe_output_o & ~$past(strobe_output_o) & ~event_o) == '0)
    else $error("strobe rose without transfer");
  a_strobe_holds: assert property (
    $rose(strobe_output_o[2]) |=> strobe_output_o[2])
    else $error("strobe dropped too soon");
endmodule // timed_io_properties
`default_nettype wire

// ### verification/pin_partner.sv
// Board model: pin wiring, pull-ups and strobe source
`default_nettype none
module pin_partner
  import tio_pkg::*;
#(
  parameter logic [NUM_PINS-1:0] PULL_UP = 32'h0000_FFFF
)
(
  // Clock
  input wire logic clk_sys_i,
  // Device side
  input wire logic [NUM_PINS-1:0] pin_o,
  input wire logic [NUM_PINS-1:0] pin_oe_n_o,
  input wire logic pull_dn_o,
  output logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PORTS-1:0] strobe_input_i,
  // Board stimulus
  input wire logic [NUM_PINS-1:0] ext_val_i,
  input wire logic [NUM_PINS-1:0] ext_en_i,
  input wire logic [NUM_PORTS-1:0] stb_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [NUM_PINS-1:0] last_r = '0;

  // Floating lines wander so stale levels never look valid
  always_ff @(posedge clk_sys_i)
  begin
    last_r <= pin_i;
  end

  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (!pin_oe_n_o[i])
        pin_i[i] = pin_o[i];
      else if (ext_en_i[i])
        pin_i[i] = ext_val_i[i];
      else if (pull_dn_o)
        pin_i[i] = 1'b0;
      else if (PULL_UP[i])
        pin_i[i] = 1'b1;
      else
        pin_i[i] = ~last_r[i];
    end
  end

  assign strobe_input_i = stb_i;
endmodule // pin_partner
`default_nettype wire

// ### verification/timed_io_top_bench.sv
// Self-checking bench for the timed I/O top level
`default_nettype none
module timed_io_top_bench
  import tio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [NUM_PINS-1:0] pin_i;
  logic [NUM_PINS-1:0] pin_o;
  logic [NUM_PINS-1:0] pin_oe_n_o;
  logic [NUM_PINS-1:0] ext_val_i = '0;
  logic [NUM_PINS-1:0] ext_en_i = '0;
  logic [NUM_PORTS-1:0] stb_i = '0;
  logic [NUM_PORTS-1:0] strobe_input_i;
  logic [NUM_PORTS-1:0] strobe_output_o;
  logic [NUM_PORTS-1:0] event_o;
  logic pull_dn_o;
  logic link_en_o;
  int err_count = 0;
  int cmp_count = 0;

  timed_io_top u_timed_io_top (
    .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pin_i, .pin_o, .pin_oe_n_o, .pull_dn_o,
    .strobe_input_i, .strobe_output_o, .event_o, .link_en_o
  );
  pin_partner u_pin_partner (
    .clk_sys_i, .pin_o, .pin_oe_n_o, .pull_dn_o, .pin_i,
    .strobe_input_i, .ext_val_i, .ext_en_i, .stb_i
  );

  // ---
  // Helpers
  // ---
  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Bounded wait; an event may already be on when called
  task automatic wait_ev(int p);
    int n;
    n = 0;
    #1;
    while (event_o[p] !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk("event", 32'(n < 200), 1);
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // ---
  // Scenarios
  // ---
  // narrow port wins, link frees pins
  task automatic t_share();
    logic [31:0] a, b;
    rd(8'h20, a);
    chk("ctrl reset", a, CTRL_RST);
    wr(8'h08, 32'h0000_0001);
    wr(8'h20, 32'h0000_0003);
    wr(8'h21, 32'hFFFF_FFFF);
    wait_ev(4);
    settle(4);
    chk("shared oe", pin_oe_n_o, 32'h0000_000F);
    wr(LINK_CTRL, 32'h0000_0001);
    settle(3);
    chk("link oe", pin_oe_n_o, 32'hF000_000F);
    chk("link flag", 32'(link_en_o), 1);
    wr(LINK_CTRL, 32'h0000_0000);
    rd(8'h23, a);
    repeat (18) @(posedge clk_sys_i);
    rd(8'h23, b);
    chk("count rate", (b - a) & 32'hFFFF, 10);
    wr(8'h20, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
  endtask

  task automatic t_outputs();
    logic [31:0] c, v, m, t;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      m = 32'((64'h1 << PORT_WIDTH[p]) - 64'h1);
      wr(8'(p*8), p == 2 ? 32'h0000_000B : 32'h0000_0003);
      rd(8'(p*8+3), c);
      t = (c + 32'd20) & 32'hFFFF;
      wr(8'(p*8+2), t);
      wr(8'(p*8+1), 32'h5A3C_96E1);
      wait_ev(p);
      chk("strobe", 32'(strobe_output_o[p]), 32'(p == 2));
      settle(2);
      chk("pins", pin_i & m, 32'h5A3C_96E1 & m);
      chk("oe", pin_oe_n_o & m, 0);
      rd(8'(p*8+4), v);
      chk("stamp", v, t);
      wr(8'(p*8), 32'h0000_0000);
    end
  endtask

  // ones float and are lifted by the board
  task automatic t_open_coll();
    wr(8'h18, 32'h0000_0007);
    wr(8'h19, 32'h0000_00F0);
    wait_ev(3);
    settle(2);
    chk("oc oe", pin_oe_n_o[15:0], 32'h00F0);
    chk("oc level", pin_i[15:0], 32'h00F0);
    chk("oc drive", pin_o[15:0], 0);
    wr(8'h18, 32'h0000_0000);
  endtask

  // capture needs both condition and strobe
  task automatic t_input();
    logic [31:0] v;
    wr(8'h16, 32'h0000_005A);
    wr(8'h10, 32'h0000_0019);
    ext_en_i <= 32'h0000_00FF;
    ext_val_i <= 32'h0000_00A5;
    stb_i <= 5'b00100;
    settle(20);
    rd(8'h15, v);
    chk("no match", v[0], 0);
    @(posedge clk_sys_i);
    stb_i <= 5'b00000;
    repeat (10) @(posedge clk_sys_i);
    ext_val_i <= 32'h0000_005A;
    settle(20);
    rd(8'h15, v);
    chk("no strobe", v[0], 0);
    @(posedge clk_sys_i);
    stb_i <= 5'b00100;
    wait_ev(2);
    @(posedge clk_sys_i);
    stb_i <= 5'b00000;
    settle(10);
    rd(8'h11, v);
    chk("captured", v, 32'h0000_005A);
    rd(8'h15, v);
    chk("valid cleared", v[0], 0);
    wr(8'h10, 32'h0000_0000);
    ext_en_i <= '0;
  endtask

  task automatic pulses(int n);
    @(posedge clk_sys_i);
    repeat (n)
    begin
      ext_val_i[0] <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      ext_val_i[0] <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
    end
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic t_clkblk();
    logic [31:0] a, b;
    wr(CLKBLK_BASE, 32'h0000_01FF);
    rd(CLKBLK_BASE, a);
    chk("block0 fixed", a, 32'(CB_RST));
    rd(8'h3F, a);
    chk("unmapped", a, 0);
    wr(8'h31, 32'h0000_0100);
    ext_en_i <= 32'h0000_0001;
    ext_val_i <= '0;
    wr(8'h18, 32'h0000_0101);
    rd(8'h1B, a);
    pulses(5);
    rd(8'h1B, b);
    chk("pin clock", (b - a) & 32'hFFFF, 5);
    wr(8'h31, 32'h0000_0101);
    rd(8'h1B, a);
    pulses(6);
    rd(8'h1B, b);
    chk("divided", (b - a) & 32'hFFFF, 3);
    wr(8'h18, 32'h0000_0000);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // pins pulled down in reset, released after
  initial
  begin
    settle(3);
    chk("pull in reset", 32'(pull_dn_o), 1);
    chk("oe in reset", pin_oe_n_o, 32'hFFFF_FFFF);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    settle(2);
    chk("pull released", 32'(pull_dn_o), 0);
    t_share();
    t_outputs();
    t_open_coll();
    t_input();
    t_clkblk();
    summarize();
  end

  // Watchdog well past the expected several hundred cycles
  initial
  begin
    #100us;
    err_count++;
    summarize();
  end
endmodule // timed_io_top_bench

bind timed_io_top timed_io_properties u_props (
  .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .pin_i, .pin_o, .pin_oe_n_o, .pull_dn_o,
  .strobe_input_i, .strobe_output_o, .event_o, .link_en_o
);
`default_nettype wire
